// ---- snx_exec.sv ----
// Execution unit for subtract_acc_from_reg and exchange_nibbles_op
// Behaviour
// - Subtract opcode computes register minus accumulator, updating carry, nibble borrow, zero.
// - Destination bit 0 sends the difference to the accumulator only.
// - Destination bit 1 writes the difference back to the register only.
// - One cycle of four phases: decode, read register, compute, write destination.
`timescale 1ns/1ps
`default_nettype none
`include "snx_consts.svh"
module snx_exec #(
	parameter int WIDTH = 8,
	parameter int IDXW = 7
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic instr_valid_in,
	input wire logic [`SNX_OPW-1:0] instr_in,
	input wire logic [WIDTH-1:0] rf_rdata_in,
	output logic [IDXW-1:0] rf_addr_out,
	output logic rf_rd_out,
	output logic [WIDTH-1:0] rf_wdata_out,
	output logic rf_we_out,
	output logic [WIDTH-1:0] acc_out,
	output logic carry_out,
	output logic nibble_borrow_flag_out,
	output logic zero_out,
	output logic [1:0] phase_out,
	output logic busy_out,
	output logic done_out
);
	snx_pkg::snx_phase_e phase_r;
	snx_pkg::snx_op_e op_r;
	logic dest_r;
	logic [IDXW-1:0] idx_r;
	logic [WIDTH-1:0] opnd_r;
	logic [WIDTH-1:0] res_r;
	logic c_r;
	logic dc_r;
	logic z_r;
	logic [WIDTH-1:0] acc_r;
	logic [WIDTH-1:0] alu_res;
	logic alu_c;
	logic alu_dc;
	logic alu_z;
	logic [WIDTH-1:0] wdata_r;
	logic we_r;
	logic done_r;
	logic rd_r;
	logic [5:0] opc;

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	// The opcode word fixes the field widths, so other sizes cannot be decoded
	if (IDXW != `SNX_IDX_HI + 1 || WIDTH != 8)
	begin : g_bad_size
		$error("snx_exec serves an 8-bit data path with a 7-bit index only");
	end

	assign opc = instr_in[`SNX_OP_HI:`SNX_OP_LO];

	// ----------------------------------------------------------------
	// Phase sequencer
	// ----------------------------------------------------------------
	// Idles in Q1 until an instruction is offered; other opcodes are not ours and pass
	// A new instruction may enter in the Q1 right after Q4, four cycles apart
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			phase_r <= snx_pkg::SNX_Q1;
		else
			case (phase_r)
				snx_pkg::SNX_Q1:
					if (instr_valid_in && (opc == `SNX_OPC_SUB || opc == `SNX_OPC_SWAP))
						phase_r <= snx_pkg::SNX_Q2;
				snx_pkg::SNX_Q2:
					phase_r <= snx_pkg::SNX_Q3;
				snx_pkg::SNX_Q3:
					phase_r <= snx_pkg::SNX_Q4;
				snx_pkg::SNX_Q4:
					phase_r <= snx_pkg::SNX_Q1;
				default:
					phase_r <= snx_pkg::SNX_Q1;
			endcase
	end

	// ----------------------------------------------------------------
	// Decode in Q1
	// ----------------------------------------------------------------
	// Foreign opcodes still load the fields; op_r at none keeps them from writing
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			op_r <= snx_pkg::SNX_NONE;
			dest_r <= 1'b0;
			idx_r <= '0;
		end
		else if (phase_r == snx_pkg::SNX_Q1 && instr_valid_in)
		begin
			if (opc == `SNX_OPC_SUB)
				op_r <= snx_pkg::SNX_SUB;
			else if (opc == `SNX_OPC_SWAP)
				op_r <= snx_pkg::SNX_SWAP;
			else
				op_r <= snx_pkg::SNX_NONE;
			dest_r <= instr_in[`SNX_DEST_BIT];
			idx_r <= instr_in[`SNX_IDX_HI:0];
		end
	end

	// ----------------------------------------------------------------
	// Read in Q2, compute in Q3
	// ----------------------------------------------------------------
	// Read strobe is registered so the file sees the address a full phase before sampling
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rd_r <= 1'b0;
		else
			rd_r <= (phase_r == snx_pkg::SNX_Q1) && instr_valid_in
				&& (opc == `SNX_OPC_SUB || opc == `SNX_OPC_SWAP);
	end

	// The operand is captured once, so the file may change its read data after Q2
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			opnd_r <= '0;
		else if (phase_r == snx_pkg::SNX_Q2)
			opnd_r <= rf_rdata_in;
	end

	snx_alu #(
		.WIDTH(WIDTH)
	) u_alu (
		.reg_val_in(opnd_r),
		.acc_val_in(acc_r),
		.swap_sel_in(op_r == snx_pkg::SNX_SWAP),
		.result_out(alu_res),
		.carry_out(alu_c),
		.nibble_borrow_flag_out(alu_dc),
		.zero_out(alu_z)
	);

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			res_r <= '0;
		else if (phase_r == snx_pkg::SNX_Q3)
			res_r <= alu_res;
	end

	// ----------------------------------------------------------------
	// Write destination in Q4, flags at the end of Q3
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			acc_r <= WIDTH'(`SNX_ACC_RST);
		else if (phase_r == snx_pkg::SNX_Q4 && op_r != snx_pkg::SNX_NONE && !dest_r)
			acc_r <= res_r;
	end

	// Flags load at the end of Q3 so they already stand beside done_out in Q4
	// Swap leaves the flags as they were
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			c_r <= `SNX_FLAG_RST;
			dc_r <= `SNX_FLAG_RST;
			z_r <= `SNX_FLAG_RST;
		end
		else if (phase_r == snx_pkg::SNX_Q3 && op_r == snx_pkg::SNX_SUB)
		begin
			c_r <= alu_c;
			dc_r <= alu_dc;
			z_r <= alu_z;
		end
	end

	// Strobe and data are registered so the file sees both settled well before its edge
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			we_r <= 1'b0;
		else
			we_r <= (phase_r == snx_pkg::SNX_Q3) && (op_r != snx_pkg::SNX_NONE) && dest_r;
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			wdata_r <= '0;
		else if (phase_r == snx_pkg::SNX_Q3)
			wdata_r <= alu_res;
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			done_r <= 1'b0;
		else
			done_r <= (phase_r == snx_pkg::SNX_Q3) && (op_r != snx_pkg::SNX_NONE);
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Busy is decoded straight from the phase register, so it adds no delay
	assign rf_addr_out = idx_r;
	assign rf_rd_out = rd_r;
	assign rf_wdata_out = wdata_r;
	assign rf_we_out = we_r;
	assign acc_out = acc_r;
	assign carry_out = c_r;
	assign nibble_borrow_flag_out = dc_r;
	assign zero_out = z_r;
	assign phase_out = phase_r;
	assign busy_out = (phase_r != snx_pkg::SNX_Q1);
	assign done_out = done_r;
endmodule
`default_nettype wire

// ---- snx_consts.svh ----
// Opcode, field and phase constants for the subtract and nibble swap datapath
`ifndef SNX_CONSTS_SVH
`define SNX_CONSTS_SVH
`define SNX_OPW 14
`define SNX_OP_HI 13
`define SNX_OP_LO 8
`define SNX_DEST_BIT 7
`define SNX_IDX_HI 6
`define SNX_OPC_SUB 6'h02
`define SNX_OPC_SWAP 6'h0E
`define SNX_ACC_RST 8'h00
`define SNX_FLAG_RST 1'b0
`define SNX_PHASES 4
`endif

// ---- snx_pkg.sv ----
// Types for the subtract and nibble swap datapath
package snx_pkg;
	typedef enum logic [1:0]
	{
		SNX_Q1 = 2'b00,
		SNX_Q2 = 2'b01,
		SNX_Q3 = 2'b11,
		SNX_Q4 = 2'b10
	} snx_phase_e;
	typedef enum logic [1:0]
	{
		SNX_NONE = 2'b00,
		SNX_SUB = 2'b01,
		SNX_SWAP = 2'b10
	} snx_op_e;
endpackage

// ---- snx_alu.sv ----
// Combinational subtract and nibble swap unit
`timescale 1ns/1ps
`default_nettype none
module snx_alu #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] reg_val_in,
	input wire logic [WIDTH-1:0] acc_val_in,
	input wire logic swap_sel_in,
	output logic [WIDTH-1:0] result_out,
	output logic carry_out,
	output logic nibble_borrow_flag_out,
	output logic zero_out
);
	localparam int H = WIDTH / 2;
	logic [WIDTH:0] diff;
	logic [H:0] low_diff;
	// Nibble carry needs two equal halves
	if (WIDTH < 2 || (WIDTH % 2) != 0)
	begin : g_bad_width
		$error("snx_alu needs an even width of at least 2");
	end
	// Two's complement: add the inverse plus one, carry set means no borrow
	assign diff = {1'b0, reg_val_in} + {1'b0, ~acc_val_in} + {{WIDTH{1'b0}}, 1'b1};
	assign low_diff = {1'b0, reg_val_in[H-1:0]} + {1'b0, ~acc_val_in[H-1:0]}
		+ {{H{1'b0}}, 1'b1};
	always_comb
	begin
		if (swap_sel_in)
			result_out = {reg_val_in[H-1:0], reg_val_in[WIDTH-1:H]};
		else
			result_out = diff[WIDTH-1:0];
	end
	assign carry_out = diff[WIDTH];
	assign nibble_borrow_flag_out = low_diff[H];
	assign zero_out = (diff[WIDTH-1:0] == {WIDTH{1'b0}});
endmodule
`default_nettype wire

// ---- snx_exec_sva.sv ----
// Assertion checker for the subtract and nibble swap unit
`timescale 1ns/1ps
`default_nettype none
module snx_exec_chk (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic instr_valid_in,
	input wire logic [13:0] instr_in,
	input wire logic [7:0] rf_rdata_in,
	input wire logic [6:0] rf_addr_out,
	input wire logic rf_rd_out,
	input wire logic rf_we_out,
	input wire logic [7:0] acc_out,
	input wire logic carry_out,
	input wire logic nibble_borrow_flag_out,
	input wire logic zero_out,
	input wire logic [1:0] phase_out,
	input wire logic done_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_take;
		phase_out == 2'h0 && instr_valid_in && instr_in[13:8] inside {6'h02, 6'h0E};
	endsequence
	sequence s_sub;
		phase_out == 2'h0 && instr_valid_in && instr_in[13:8] == 6'h02;
	endsequence
	sequence s_walk;
		phase_out == 2'h1 && rf_rd_out ##1 phase_out == 2'h3 ##1 phase_out == 2'h2 && done_out;
	endsequence
	AST_PHASES: assert property (s_take |=> s_walk ##1 phase_out == 2'h0)
		else $error("phase walk broken");
	AST_ADDR: assert property (s_take |=> rf_addr_out == $past(instr_in[6:0]))
		else $error("register index wrong");
	AST_DEST: assert property (s_take ##3 1'b1 |-> rf_we_out == $past(instr_in[7], 3))
		else $error("write strobe wrong");
	AST_ACC_KEEP: assert property (s_take and instr_in[7] |=> $stable(acc_out) [*5])
		else $error("acc changed");
	AST_SWAP_FLAGS: assert property (s_take and instr_in[13:8] == 6'h0E |=>
		$stable({carry_out, nibble_borrow_flag_out, zero_out}) [*5])
		else $error("swap touched flags");
	AST_SUB_FLAGS: assert property (s_sub ##3 1'b1 |->
		zero_out == ($past(rf_rdata_in, 2) == acc_out)
		&& carry_out == ($past(rf_rdata_in, 2) >= acc_out)
		&& nibble_borrow_flag_out == ($past(rf_rdata_in[3:0], 2) >= acc_out[3:0]))
		else $error("subtract flags wrong");
	AST_FOREIGN: assert property (phase_out == 2'h0 && instr_valid_in
		&& !(instr_in[13:8] inside {6'h02, 6'h0E}) |=> phase_out == 2'h0 && !rf_rd_out)
		else $error("foreign opcode started a cycle");
	AST_WE_DONE: assert property (rf_we_out |-> done_out)
		else $error("write strobe outside Q4");
	AST_DONE_PULSE: assert property (done_out |=> !done_out)
		else $error("done held too long");
endmodule
bind snx_exec snx_exec_chk u_chk (.sys_clk_in, .rstn_in, .instr_valid_in, .instr_in, .rf_rdata_in,
	.rf_addr_out, .rf_rd_out, .rf_we_out, .acc_out, .carry_out, .nibble_borrow_flag_out,
	.zero_out, .phase_out, .done_out);
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the subtract and nibble swap unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic instr_valid_in = 1'b0;
	logic [13:0] instr_in = 14'h0000;
	logic [7:0] rf_rdata_in = 8'h00;
	logic [6:0] rf_addr_out;
	logic rf_rd_out, rf_we_out, carry_out, nibble_borrow_flag_out, zero_out, busy_out, done_out;
	logic [7:0] rf_wdata_out, acc_out;
	logic [1:0] phase_out;
	logic [11:0] snap;
	int err_total = 0;
	int check_count = 0;
	always #5 sys_clk_in = ~sys_clk_in;
	snx_exec u_dut (.sys_clk_in, .rstn_in, .instr_valid_in, .instr_in, .rf_rdata_in,
		.rf_addr_out, .rf_rd_out, .rf_wdata_out, .rf_we_out, .acc_out, .carry_out,
		.nibble_borrow_flag_out, .zero_out, .phase_out, .busy_out, .done_out);
	task automatic summarize();
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Snapshot of write strobe, flags and write data is taken in the done cycle
	task automatic run(input logic [5:0] op, input logic dest, input logic [7:0] rv);
		int i;
		@(posedge sys_clk_in);
		instr_valid_in <= 1'b1;
		instr_in <= {op, dest, 7'h15};
		rf_rdata_in <= rv;
		@(posedge sys_clk_in);
		instr_valid_in <= 1'b0;
		@(negedge sys_clk_in);
		chk("read phase", {rf_rd_out, phase_out, busy_out, done_out}, 5'h16);
		for (i = 1; i < 8 && done_out !== 1'b1; i++)
			@(negedge sys_clk_in);
		if (i == 8)
		begin
			err_total++;
			summarize();
		end
		chk("done cycle", 12'(i), 12'h003);
		chk("index", {rf_addr_out, phase_out, busy_out}, 10'h0AD);
		snap = {rf_we_out, carry_out, nibble_borrow_flag_out, zero_out, rf_wdata_out};
		@(negedge sys_clk_in);
		chk("idle phase", {phase_out, busy_out, done_out, rf_we_out}, 5'h00);
	endtask
	task automatic t_sub_to_acc();
		run(6'h0E, 1'b0, 8'h20);
		chk("swap acc", acc_out, 8'h02);
		run(6'h02, 1'b0, 8'h03);
		chk("sub flags", snap[11:8], 4'h6);
		chk("sub acc", acc_out, 8'h01);
	endtask
	task automatic t_sub_to_reg();
		run(6'h02, 1'b1, 8'h01);
		chk("sub reg", snap, 12'hF00);
		chk("acc kept", acc_out, 8'h01);
	endtask
	task automatic t_swap_reg();
		run(6'h0E, 1'b1, 8'hA5);
		chk("swap reg", snap, 12'hF5A);
		chk("acc kept", acc_out, 8'h01);
	endtask
	task automatic t_borrow();
		run(6'h02, 1'b0, 8'h00);
		chk("borrow flags", snap[11:8], 4'h0);
		chk("borrow acc", acc_out, 8'hFF);
	endtask
	// Reset applied while the unit idles in Q1 between runs must clear every output register
	task automatic t_reset();
		@(posedge sys_clk_in);
		rstn_in <= 1'b0;
		@(negedge sys_clk_in);
		chk("reset acc", acc_out, 8'h00);
		chk("reset wdata", rf_wdata_out, 8'h00);
		chk("reset ctl", {rf_addr_out, phase_out, busy_out, done_out, rf_we_out}, 12'h000);
		chk("reset flags", {carry_out, nibble_borrow_flag_out, zero_out, rf_rd_out}, 4'h0);
		@(posedge sys_clk_in);
		rstn_in <= 1'b1;
	endtask
	// Foreign opcode is passed by, and a swap offered while busy is refused
	task automatic t_ignore();
		@(posedge sys_clk_in);
		instr_valid_in <= 1'b1;
		instr_in <= {6'h07, 1'b0, 7'h15};
		rf_rdata_in <= 8'h10;
		@(posedge sys_clk_in);
		instr_in <= {6'h02, 1'b0, 7'h15};
		@(negedge sys_clk_in);
		chk("foreign op", {phase_out, busy_out, rf_rd_out}, 4'h0);
		@(posedge sys_clk_in);
		instr_in <= {6'h0E, 1'b0, 7'h15};
		repeat (3) @(posedge sys_clk_in);
		instr_valid_in <= 1'b0;
		repeat (2) @(negedge sys_clk_in);
		chk("refused while busy", {phase_out, acc_out}, 10'h011);
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		t_sub_to_acc();
		t_sub_to_reg();
		t_swap_reg();
		t_reset();
		t_sub_to_acc();
		t_borrow();
		t_ignore();
		summarize();
	end
endmodule
`default_nettype wire
